// File: verilog/config_port_pin_mux.sv
// Configuration port ownership, status pins, key gating and refresh sequencing
`timescale 1ns/1ps
`include "config_port_pin_mux_consts.svh"

module config_port_pin_mux (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Nonvolatile feature bits
  input wire logic scan_keep_i,
  input wire logic slave_spi_keep_i,
  input wire config_port_pin_mux_pkg::master_spi_t master_spi_i,
  input wire logic image_external_i,
  input wire logic i2c_keep_i,
  input wire config_port_pin_mux_pkg::status_pin_setting_t status_pin_setting_i,
  input wire logic key_protect_on_i,
  input wire logic key_protect_full_i,
  input wire logic [`CPM_KEY_W-1:0] stored_key_i,
  // Configuration engine events
  input wire logic cfg_done_i,
  input wire logic image_fail_i,
  input wire logic refresh_cmd_i,
  input wire logic refresh_done_i,
  // Device pins
  input wire logic scan_pin_select_i,
  input wire logic reconfig_request_n_i,
  // Key and operation requests
  input wire logic key_valid_i,
  input wire logic [`CPM_KEY_W-1:0] key_data_i,
  input wire logic op_valid_i,
  input wire config_port_pin_mux_pkg::op_kind_t op_kind_i,
  // Pin ownership
  output logic user_mode_o,
  output logic scan_tap_route_o,
  output logic scan_gpio_o,
  output logic spi_cfg_attach_o,
  output logic spi_hard_master_o,
  output logic spi_gpio_o,
  output logic i2c_cfg_attach_o,
  output logic i2c_ctrl_allow_o,
  output logic i2c_gpio_o,
  output logic [`CPM_STATUS_PINS-1:0] status_kept_o,
  output logic [`CPM_STATUS_PINS-1:0] status_gpio_o,
  // Boot and sequencing
  output logic boot_external_o,
  output logic boot_dual_o,
  output logic golden_select_o,
  output logic reconfig_start_o,
  output logic io_hold_o,
  output logic global_set_reset_o,
  // Access control
  output logic unlocked_o,
  output logic op_grant_o,
  output logic op_deny_o
);

  // Status pin keep decode
  function automatic logic status_keeps(
    input config_port_pin_mux_pkg::status_pin_setting_t s,
    input int unsigned idx
  );
    case (s)
      config_port_pin_mux_pkg::STAT_RECONFIG_ONLY: status_keeps = (idx == 0);
      config_port_pin_mux_pkg::STAT_RECONFIG_DONE: status_keeps = (idx <= 1);
      config_port_pin_mux_pkg::STAT_ALL_STATUS_PINS: status_keeps = 1'b1;
      default: status_keeps = 1'b0;
    endcase
  endfunction : status_keeps

  // Synchronised pins
  logic [1:0] pins_sync;
  logic scan_sel_sync;
  logic reconfig_n_sync;

  pin_sync2 u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .async_i({reconfig_request_n_i, scan_pin_select_i}),
    .sync_o(pins_sync)
  );

  assign scan_sel_sync = pins_sync[`CPM_SYNC_SCAN_SEL];
  assign reconfig_n_sync = pins_sync[`CPM_SYNC_RECONFIG];

  // Sequencer state
  config_port_pin_mux_pkg::state_t state_reg;
  config_port_pin_mux_pkg::state_t state_next;
  logic [`CPM_WAKE_CNT_W-1:0] wake_cnt_reg;
  logic [`CPM_WAKE_CNT_W-1:0] wake_cnt_next;
  logic golden_reg;
  logic golden_next;
  logic reconfig_start_reg;
  logic reconfig_start_next;
  logic sample_now;
  logic reconfig_go;
  logic refresh_go;

  // Sampled feature bits
  logic scan_keep_reg;
  logic scan_keep_next;
  logic sspi_keep_reg;
  logic sspi_keep_next;
  config_port_pin_mux_pkg::master_spi_t mspi_reg;
  config_port_pin_mux_pkg::master_spi_t mspi_next;
  logic img_ext_reg;
  logic img_ext_next;
  logic i2c_keep_reg;
  logic i2c_keep_next;
  config_port_pin_mux_pkg::status_pin_setting_t stat_reg;
  config_port_pin_mux_pkg::status_pin_setting_t stat_next;
  logic protect_reg;
  logic protect_next;
  logic protect_full_reg;
  logic protect_full_next;

  // Ownership registers
  logic [9:0] own_reg;
  logic [9:0] own_next;
  logic [`CPM_STATUS_PINS-1:0] kept_reg;
  logic [`CPM_STATUS_PINS-1:0] kept_next;
  logic [`CPM_STATUS_PINS-1:0] kept_calc;

  // Access registers
  logic unlocked_reg;
  logic unlocked_next;
  logic grant_reg;
  logic grant_next;
  logic deny_reg;
  logic deny_next;
  logic edit_op;
  logic needs_key;

  genvar gi;
  generate
    for (gi = 0; gi < `CPM_STATUS_PINS; gi++) begin : g_status
      assign kept_calc[gi] = status_keeps(stat_next, gi);
      assign status_gpio_o[gi] = user_mode_o & ~kept_reg[gi];
    end
  endgenerate

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    wake_cnt_next = wake_cnt_reg;
    golden_next = golden_reg;
    sample_now = 1'b0;
    reconfig_go = (state_reg == config_port_pin_mux_pkg::ST_USER) &&
                  kept_reg[`CPM_PIN_RECONFIG] && !reconfig_n_sync;
    refresh_go = (state_reg == config_port_pin_mux_pkg::ST_USER) && refresh_cmd_i &&
                 (own_reg[0] || own_reg[2] || own_reg[6]) &&
                 (!protect_reg || unlocked_reg);
    reconfig_start_next = reconfig_go;
    case (state_reg)
      config_port_pin_mux_pkg::ST_CONFIG: begin
        if (image_fail_i) begin
          golden_next = 1'b1;
        end else if (cfg_done_i) begin
          sample_now = 1'b1;
          state_next = config_port_pin_mux_pkg::ST_USER;
        end
      end
      config_port_pin_mux_pkg::ST_USER: begin
        if (reconfig_go) begin
          state_next = config_port_pin_mux_pkg::ST_CONFIG;
        end else if (refresh_go) begin
          state_next = config_port_pin_mux_pkg::ST_REFRESH;
        end
      end
      config_port_pin_mux_pkg::ST_REFRESH: begin
        if (image_fail_i) begin
          golden_next = 1'b1;
        end else if (refresh_done_i) begin
          sample_now = 1'b1;
          wake_cnt_next = '0;
          state_next = config_port_pin_mux_pkg::ST_WAKE;
        end
      end
      config_port_pin_mux_pkg::ST_WAKE: begin
        wake_cnt_next = wake_cnt_reg + 1'b1;
        if (wake_cnt_reg == `CPM_WAKE_CNT_W'(`CPM_WAKE_RST_CYCLES - 1)) begin
          state_next = config_port_pin_mux_pkg::ST_USER;
        end
      end
      default: begin
        state_next = config_port_pin_mux_pkg::ST_CONFIG;
      end
    endcase
  end

  // Feature bit sampling
  always_comb begin
    scan_keep_next = scan_keep_reg;
    sspi_keep_next = sspi_keep_reg;
    mspi_next = mspi_reg;
    img_ext_next = img_ext_reg;
    i2c_keep_next = i2c_keep_reg;
    stat_next = stat_reg;
    protect_next = protect_reg;
    protect_full_next = protect_full_reg;
    if (sample_now) begin
      scan_keep_next = scan_keep_i;
      sspi_keep_next = slave_spi_keep_i;
      mspi_next = master_spi_i;
      img_ext_next = image_external_i;
      i2c_keep_next = i2c_keep_i;
      stat_next = status_pin_setting_i;
      protect_next = key_protect_on_i | key_protect_full_i;
      protect_full_next = key_protect_full_i;
    end
  end

  // Ownership next values
  always_comb begin
    own_next = own_reg;
    kept_next = kept_reg;
    if (state_next == config_port_pin_mux_pkg::ST_CONFIG) begin
      own_next = 10'h045;
      kept_next = `CPM_STATUS_KEPT_RST;
    end else if (state_next == config_port_pin_mux_pkg::ST_USER) begin
      own_next[0] = scan_keep_next | scan_sel_sync;
      own_next[1] = ~scan_keep_next & ~scan_sel_sync;
      own_next[2] = sspi_keep_next;
      own_next[3] = mspi_next != config_port_pin_mux_pkg::SPI_OFF;
      own_next[4] = ~sspi_keep_next && (mspi_next == config_port_pin_mux_pkg::SPI_OFF);
      own_next[5] = (mspi_next == config_port_pin_mux_pkg::SPI_ON) && img_ext_next;
      own_next[6] = i2c_keep_next;
      own_next[7] = i2c_keep_next;
      own_next[8] = ~i2c_keep_next;
      own_next[9] = (mspi_next == config_port_pin_mux_pkg::SPI_ON) && !img_ext_next;
      kept_next = kept_calc;
    end
  end

  // Key check and operation gating
  always_comb begin
    edit_op = (op_kind_i == config_port_pin_mux_pkg::OP_WRITE) ||
              (op_kind_i == config_port_pin_mux_pkg::OP_VERIFY) ||
              (op_kind_i == config_port_pin_mux_pkg::OP_ERASE);
    needs_key = protect_reg &&
                (edit_op || (protect_full_reg &&
                 op_kind_i != config_port_pin_mux_pkg::OP_READ_ID));
    unlocked_next = unlocked_reg;
    if (state_next == config_port_pin_mux_pkg::ST_CONFIG) begin
      unlocked_next = 1'b0;
    end
    if (key_valid_i) begin
      unlocked_next = (key_data_i == stored_key_i);
    end
    grant_next = op_valid_i && (!needs_key || unlocked_reg);
    deny_next = op_valid_i && needs_key && !unlocked_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_reg <= config_port_pin_mux_pkg::ST_CONFIG;
      wake_cnt_reg <= '0;
      golden_reg <= 1'b0;
      reconfig_start_reg <= 1'b0;
      scan_keep_reg <= 1'b1;
      sspi_keep_reg <= 1'b0;
      mspi_reg <= config_port_pin_mux_pkg::SPI_OFF;
      img_ext_reg <= 1'b0;
      i2c_keep_reg <= 1'b0;
      stat_reg <= config_port_pin_mux_pkg::STAT_OFF;
      protect_reg <= 1'b0;
      protect_full_reg <= 1'b0;
      own_reg <= 10'h045;
      kept_reg <= `CPM_STATUS_KEPT_RST;
      unlocked_reg <= 1'b0;
      grant_reg <= 1'b0;
      deny_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wake_cnt_reg <= wake_cnt_next;
      golden_reg <= golden_next;
      reconfig_start_reg <= reconfig_start_next;
      scan_keep_reg <= scan_keep_next;
      sspi_keep_reg <= sspi_keep_next;
      mspi_reg <= mspi_next;
      img_ext_reg <= img_ext_next;
      i2c_keep_reg <= i2c_keep_next;
      stat_reg <= stat_next;
      protect_reg <= protect_next;
      protect_full_reg <= protect_full_next;
      own_reg <= own_next;
      kept_reg <= kept_next;
      unlocked_reg <= unlocked_next;
      grant_reg <= grant_next;
      deny_reg <= deny_next;
    end
  end

  // Outputs
  assign user_mode_o = state_reg == config_port_pin_mux_pkg::ST_USER;
  assign scan_tap_route_o = own_reg[0];
  assign scan_gpio_o = own_reg[1];
  assign spi_cfg_attach_o = own_reg[2];
  assign spi_hard_master_o = own_reg[3];
  assign spi_gpio_o = own_reg[4];
  assign boot_external_o = own_reg[5];
  assign i2c_cfg_attach_o = own_reg[6];
  assign i2c_ctrl_allow_o = own_reg[7];
  assign i2c_gpio_o = own_reg[8];
  assign boot_dual_o = own_reg[9];
  assign status_kept_o = kept_reg;
  assign golden_select_o = golden_reg;
  assign reconfig_start_o = reconfig_start_reg;
  assign io_hold_o = state_reg == config_port_pin_mux_pkg::ST_REFRESH;
  assign global_set_reset_o = state_reg == config_port_pin_mux_pkg::ST_WAKE;
  assign unlocked_o = unlocked_reg;
  assign op_grant_o = grant_reg;
  assign op_deny_o = deny_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_scan_keep;
    user_mode_o && scan_keep_reg |-> scan_tap_route_o && !scan_gpio_o;
  endproperty
  a_scan_keep: assert property (p_scan_keep) else $error("Scan keep lost TAP");

  property p_scan_select;
    user_mode_o && $past(user_mode_o) && !scan_keep_reg && !$past(scan_sel_sync)
      |-> scan_gpio_o && !scan_tap_route_o;
  endproperty
  a_scan_select: assert property (p_scan_select) else $error("Select low not GPIO");

  property p_spi_gpio;
    spi_gpio_o && !io_hold_o && !global_set_reset_o
      |-> user_mode_o && !sspi_keep_reg && mspi_reg == config_port_pin_mux_pkg::SPI_OFF;
  endproperty
  a_spi_gpio: assert property (p_spi_gpio) else $error("SPI GPIO while kept");

  property p_boot_mode;
    user_mode_o |-> boot_dual_o == (mspi_reg == config_port_pin_mux_pkg::SPI_ON && !img_ext_reg)
      && boot_external_o == (mspi_reg == config_port_pin_mux_pkg::SPI_ON && img_ext_reg);
  endproperty
  a_boot_mode: assert property (p_boot_mode) else $error("Boot mode wrong");

  property p_hard_spi;
    user_mode_o && mspi_reg != config_port_pin_mux_pkg::SPI_OFF |-> spi_hard_master_o;
  endproperty
  a_hard_spi: assert property (p_hard_spi) else $error("Hard SPI not given pins");

  property p_i2c_release;
    user_mode_o && !i2c_keep_reg |-> i2c_gpio_o && !i2c_ctrl_allow_o && !i2c_cfg_attach_o;
  endproperty
  a_i2c_release: assert property (p_i2c_release) else $error("Two-wire not released");

  property p_reconfig_pin;
    user_mode_o && kept_reg[`CPM_PIN_RECONFIG] && !reconfig_n_sync
      |=> reconfig_start_o && !user_mode_o ##1 !reconfig_start_o;
  endproperty
  a_reconfig_pin: assert property (p_reconfig_pin) else $error("Request pin ignored");

  property p_key_gate;
    op_valid_i && protect_reg && !unlocked_reg && op_kind_i == config_port_pin_mux_pkg::OP_ERASE
      |=> op_deny_o && !op_grant_o;
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("Erase without key");

  property p_read_id;
    op_valid_i && op_kind_i == config_port_pin_mux_pkg::OP_READ_ID |=> op_grant_o;
  endproperty
  a_read_id: assert property (p_read_id) else $error("Read ID refused");

  property p_refresh_wake;
    state_reg == config_port_pin_mux_pkg::ST_REFRESH && !image_fail_i && refresh_done_i
      |=> global_set_reset_o [*4] ##1 user_mode_o && !global_set_reset_o;
  endproperty
  a_refresh_wake: assert property (p_refresh_wake) else $error("Wake reset pulse wrong");

  property p_golden;
    state_reg == config_port_pin_mux_pkg::ST_CONFIG && image_fail_i |=> golden_select_o;
  endproperty
  a_golden: assert property (p_golden) else $error("Golden image not selected");

  property p_apply_before_user;
    $rose(user_mode_o) |-> status_kept_o == {status_keeps(stat_reg, 2),
      status_keeps(stat_reg, 1), status_keeps(stat_reg, 0)};
  endproperty
  a_apply_before_user: assert property (p_apply_before_user) else $error("Late pin apply");

endmodule : config_port_pin_mux

// File: shared/config_port_pin_mux_consts.svh
// Constants for the configuration port pin multiplexer
`ifndef CONFIG_PORT_PIN_MUX_CONSTS_SVH
`define CONFIG_PORT_PIN_MUX_CONSTS_SVH

// Clock and wake-up timing
`define CPM_CLK_PERIOD_NS 10
`define CPM_WAKE_RST_TIME_NS 40
`define CPM_WAKE_RST_CYCLES ((`CPM_WAKE_RST_TIME_NS + `CPM_CLK_PERIOD_NS - 1) / `CPM_CLK_PERIOD_NS)
`define CPM_WAKE_CNT_W 3

// Widths
`define CPM_KEY_W 64
`define CPM_STATUS_PINS 3

// Status pin positions
`define CPM_PIN_RECONFIG 0
`define CPM_PIN_DONE 1
`define CPM_PIN_INIT 2

// Pin synchroniser positions
`define CPM_SYNC_SCAN_SEL 0
`define CPM_SYNC_RECONFIG 1

// Reset values
`define CPM_SYNC_RST 2'h3
`define CPM_STATUS_KEPT_RST 3'h7

`endif

// File: shared/config_port_pin_mux_pkg.sv
// Types for the configuration port pin multiplexer
package config_port_pin_mux_pkg;

  typedef enum logic [3:0] {
    ST_CONFIG = 4'h1,
    ST_USER = 4'h2,
    ST_REFRESH = 4'h4,
    ST_WAKE = 4'h8
  } state_t;

  typedef enum logic [1:0] {
    SPI_OFF = 2'h0,
    SPI_ON = 2'h1,
    SPI_USER_ONLY_VALUE = 2'h2
  } master_spi_t;

  typedef enum logic [1:0] {
    STAT_OFF = 2'h0,
    STAT_RECONFIG_ONLY = 2'h1,
    STAT_RECONFIG_DONE = 2'h2,
    STAT_ALL_STATUS_PINS = 2'h3
  } status_pin_setting_t;

  typedef enum logic [2:0] {
    OP_READ_ID = 3'h0,
    OP_READ_STATUS = 3'h1,
    OP_WRITE = 3'h2,
    OP_VERIFY = 3'h3,
    OP_ERASE = 3'h4
  } op_kind_t;

endpackage : config_port_pin_mux_pkg

// File: verilog/pin_sync2.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`include "config_port_pin_mux_consts.svh"

module pin_sync2 (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Pins in, synchronised levels out
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);

  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;

  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      meta_reg <= `CPM_SYNC_RST;
      sync_reg <= `CPM_SYNC_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;

endmodule : pin_sync2

// File: tb/config_master_model.sv
// Behavioural external configuration master issuing keys and operations
`timescale 1ns/1ps
`include "config_port_pin_mux_consts.svh"

module config_master_model (
  // Clock
  input wire logic ref_clk_i,
  // Requests to the device
  output logic key_valid_o,
  output logic [`CPM_KEY_W-1:0] key_data_o,
  output logic op_valid_o,
  output config_port_pin_mux_pkg::op_kind_t op_kind_o
);
  initial begin
    key_valid_o = 1'b0;
    key_data_o = {`CPM_KEY_W{1'b0}};
    op_valid_o = 1'b0;
    op_kind_o = config_port_pin_mux_pkg::OP_READ_ID;
  end

  // One key for one cycle after a gap; idle bus scrambled
  task automatic send_key(input logic [`CPM_KEY_W-1:0] key, input int gap);
    repeat (gap + 1) @(negedge ref_clk_i);
    key_valid_o = 1'b1;
    key_data_o = key;
    @(negedge ref_clk_i);
    key_valid_o = 1'b0;
    key_data_o = ~key;
  endtask : send_key

  // One request for one cycle after a gap; idle kind scrambled
  task automatic send_op(input config_port_pin_mux_pkg::op_kind_t kind, input int gap);
    repeat (gap + 1) @(negedge ref_clk_i);
    op_valid_o = 1'b1;
    op_kind_o = kind;
    @(negedge ref_clk_i);
    op_valid_o = 1'b0;
    op_kind_o = config_port_pin_mux_pkg::op_kind_t'(~kind);
  endtask : send_op
endmodule : config_master_model

// File: tb/config_port_pin_mux_tb_top.sv
// Self-checking testbench for the configuration port pin multiplexer
`timescale 1ns/1ps
`include "config_port_pin_mux_consts.svh"

module config_port_pin_mux_tb_top;
  // Stimulus
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] feat = 8'h00;
  logic [7:0] feat_drv = 8'h00;
  logic prot_on = 1'b0;
  logic prot_full = 1'b0;
  logic cfg_done = 1'b0;
  logic img_fail = 1'b0;
  logic refresh_cmd = 1'b0;
  logic refresh_done = 1'b0;
  logic sel = 1'b1;
  logic reconfig_n = 1'b1;
  logic [`CPM_KEY_W-1:0] skey;
  logic key_valid;
  logic [`CPM_KEY_W-1:0] key_data;
  logic op_valid;
  config_port_pin_mux_pkg::op_kind_t op_kind;
  // Observed
  logic [16:0] own;
  logic golden, rc_start, io_hold, wake_rst, unlocked, grant, deny;
  logic [1:0] exp_q[$];
  int errors = 0;
  int check_count = 0;
  int seed = 32'ha82a2b3f;
  int n;
  logic seen;

  always #(`CPM_CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

  config_port_pin_mux i_config_port_pin_mux (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .scan_keep_i(feat_drv[7]),
    .slave_spi_keep_i(feat_drv[6]),
    .master_spi_i(config_port_pin_mux_pkg::master_spi_t'(feat_drv[5:4])),
    .image_external_i(feat_drv[3]),
    .i2c_keep_i(feat_drv[2]),
    .status_pin_setting_i(config_port_pin_mux_pkg::status_pin_setting_t'(feat_drv[1:0])),
    .key_protect_on_i(prot_on),
    .key_protect_full_i(prot_full),
    .stored_key_i(skey),
    .cfg_done_i(cfg_done),
    .image_fail_i(img_fail),
    .refresh_cmd_i(refresh_cmd),
    .refresh_done_i(refresh_done),
    .scan_pin_select_i(sel),
    .reconfig_request_n_i(reconfig_n),
    .key_valid_i(key_valid),
    .key_data_i(key_data),
    .op_valid_i(op_valid),
    .op_kind_i(op_kind),
    .user_mode_o(own[16]),
    .scan_tap_route_o(own[15]),
    .scan_gpio_o(own[14]),
    .spi_cfg_attach_o(own[13]),
    .spi_hard_master_o(own[12]),
    .spi_gpio_o(own[11]),
    .i2c_cfg_attach_o(own[10]),
    .i2c_ctrl_allow_o(own[9]),
    .i2c_gpio_o(own[8]),
    .status_kept_o(own[7:5]),
    .status_gpio_o(own[4:2]),
    .boot_external_o(own[1]),
    .boot_dual_o(own[0]),
    .golden_select_o(golden),
    .reconfig_start_o(rc_start),
    .io_hold_o(io_hold),
    .global_set_reset_o(wake_rst),
    .unlocked_o(unlocked),
    .op_grant_o(grant),
    .op_deny_o(deny)
  );

  config_master_model i_config_master_model (
    .ref_clk_i(ref_clk_i),
    .key_valid_o(key_valid),
    .key_data_o(key_data),
    .op_valid_o(op_valid),
    .op_kind_o(op_kind)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Reset for four cycles, then finish configuration
  task automatic configure(input logic fail);
    rstn_i = 1'b0;
    feat_drv = feat;
    repeat (4) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    img_fail = fail;
    cfg_done = 1'b1;
    @(negedge ref_clk_i);
    img_fail = 1'b0;
    if (fail) begin
      check(own[16], 1'b0, "fail");
      @(negedge ref_clk_i);
    end
    cfg_done = 1'b0;
  endtask : configure

  task automatic op(input config_port_pin_mux_pkg::op_kind_t k, input logic g);
    exp_q.push_back({g, ~g});
    i_config_master_model.send_op(k, $unsigned($random(seed)) % 3);
  endtask : op

  task automatic key(input logic [`CPM_KEY_W-1:0] k);
    i_config_master_model.send_key(k, $unsigned($random(seed)) % 3);
  endtask : key

  // Answer monitor
  always @(negedge ref_clk_i) begin
    if (grant === 1'b1 || deny === 1'b1) begin
      if (exp_q.size() == 0) exp_q.push_back(2'h3);
      check({grant, deny}, exp_q.pop_front(), "op");
    end
  end

  initial begin
    #100000;
    errors++;
    finish_test();
  end

  initial begin
    logic [2:0] k;
    logic ms;
    logic on;
    skey = {$random(seed), $random(seed)};
    for (int i = 0; i < 12; i++) begin
      feat = 8'($random(seed));
      feat[5:4] = 2'(i % 3);
      feat[1:0] = 2'(i % 4);
      sel = 1'($random(seed));
      configure(1'b0);
      feat_drv = ~feat;
      repeat (3) @(negedge ref_clk_i);
      k = feat[1:0] == 2'h0 ? 3'h0 : feat[1:0] == 2'h1 ? 3'h1 : feat[1:0] == 2'h2 ? 3'h3 : 3'h7;
      ms = feat[5:4] != 2'h0;
      on = feat[5:4] == 2'h1;
      check(own, {1'b1, feat[7] | sel, ~feat[7] & ~sel, feat[6], ms, ~feat[6] & ~ms,
        feat[2], feat[2], ~feat[2], k, ~k, on & feat[3], on & ~feat[3]}, "own");
      reconfig_n = 1'b0;
      seen = 1'b0;
      repeat (6) begin
        @(negedge ref_clk_i);
        seen = seen | rc_start;
      end
      check(own[16], feat[1:0] == 2'h0, "pin");
      check(seen, feat[1:0] != 2'h0, "start");
      reconfig_n = 1'b1;
    end
    feat = 8'h40;
    configure(1'b1);
    check(golden, 1'b1, "gold");
    refresh_cmd = 1'b1;
    @(negedge ref_clk_i);
    refresh_cmd = 1'b0;
    check(io_hold, 1'b1, "hold");
    repeat (3) @(negedge ref_clk_i);
    refresh_done = 1'b1;
    @(negedge ref_clk_i);
    refresh_done = 1'b0;
    n = wake_rst;
    repeat (8) begin
      @(negedge ref_clk_i);
      n += wake_rst;
    end
    check(n, `CPM_WAKE_RST_CYCLES, "wake reset");
    check({own[16], io_hold}, 2'h2, "wake");
    prot_on = 1'b1;
    configure(1'b0);
    refresh_cmd = 1'b1;
    @(negedge ref_clk_i);
    refresh_cmd = 1'b0;
    check(io_hold, 1'b0, "locked");
    op(config_port_pin_mux_pkg::OP_WRITE, 1'b0);
    op(config_port_pin_mux_pkg::OP_READ_ID, 1'b1);
    op(config_port_pin_mux_pkg::OP_READ_STATUS, 1'b1);
    key(~skey);
    check(unlocked, 1'b0, "bad key");
    op(config_port_pin_mux_pkg::OP_VERIFY, 1'b0);
    key(skey);
    check(unlocked, 1'b1, "key");
    op(config_port_pin_mux_pkg::OP_ERASE, 1'b1);
    op(config_port_pin_mux_pkg::OP_WRITE, 1'b1);
    prot_on = 1'b0;
    prot_full = 1'b1;
    configure(1'b0);
    op(config_port_pin_mux_pkg::OP_READ_STATUS, 1'b0);
    op(config_port_pin_mux_pkg::OP_READ_ID, 1'b1);
    key(skey);
    op(config_port_pin_mux_pkg::OP_READ_STATUS, 1'b1);
    prot_full = 1'b0;
    configure(1'b0);
    op(config_port_pin_mux_pkg::OP_VERIFY, 1'b1);
    repeat (2) @(negedge ref_clk_i);
    check(exp_q.size(), 0, "queue");
    finish_test();
  end
endmodule : config_port_pin_mux_tb_top
